// File: core/uefis_pkg.sv
/*
 * package for the usb endpoint fifo event status block: register map,
 * flag layout, reset values and the carrier types of the block.
 * assumes one 10 mhz system clock and a byte-addressed register port.
 */
`default_nettype none

package uefis_pkg;

  // ************************************************************
  // register map (byte addresses on the register port)
  // ************************************************************
  localparam logic [31:0] UEFIS_ADDR_FLAGS_LOW = 32'h9010_3000;
  localparam logic [31:0] UEFIS_ADDR_EN_LOW    = 32'h9010_3004;
  localparam logic [31:0] UEFIS_ADDR_FLAGS_MID = 32'h9010_3010;
  localparam logic [31:0] UEFIS_ADDR_EN_MID    = 32'h9010_3014;

  localparam logic [31:0] UEFIS_RST_FLAGS      = 32'h0000_0000;
  localparam logic [31:0] UEFIS_RST_EN         = 32'h0000_0000;
  localparam logic [31:0] UEFIS_RDATA_IDLE     = 32'h0000_0000;

  // ************************************************************
  // fifo layout
  // ************************************************************
  localparam int unsigned UEFIS_NUM_FIFO  = 6;
  localparam int unsigned UEFIS_TRIP_W    = 3;

  // fifo index 0 is fifo 1 (control out), index 1 is fifo 2 (control in)
  localparam int unsigned UEFIS_FIFO_CTRL_OUT = 0;
  localparam int unsigned UEFIS_FIFO_CTRL_IN  = 1;

  // top bit of each flag triplet, and the register it lives in
  localparam int unsigned UEFIS_TRIP_MSB [UEFIS_NUM_FIFO] = '{7, 15, 7, 15, 23, 31};
  localparam bit          UEFIS_TRIP_MID [UEFIS_NUM_FIFO] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  // defined flag positions of each status and enable register
  localparam logic [31:0] UEFIS_MASK_LOW = 32'h0000_e0e0;
  localparam logic [31:0] UEFIS_MASK_MID = 32'he0e0_e0e0;

  // ************************************************************
  // carrier types
  // ************************************************************
  // handshake outcomes reported by the protocol engine, one cycle pulses
  typedef struct packed {
    logic pkt_sent;     // data packet sent to the host
    logic host_ack;     // ack received from the host
    logic ack_timeout;  // no ack from the host after a data packet
    logic ack_sent;     // ack sent to the host
    logic pkt_rcvd;     // packet received from the host
    logic rx_err;       // transmission error in a received packet
    logic nak_sent;     // nak sent to the host after a setup packet
  } uefis_evt_t;

  // one flag triplet, msb first as it lies in the register
  typedef struct packed {
    logic acked;
    logic refused;
    logic fault;
  } uefis_trip_t;

endpackage

`default_nettype wire

// File: core/uefis_flag_cell.sv
/*
 * one catch-and-hold flag triplet of an endpoint fifo.
 * assumes set conditions and write-one bits arrive on the same clock.
 */
`default_nettype none

module uefis_flag_cell
  import uefis_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // condition and software write
  input  wire uefis_trip_t set_i,
  input  wire uefis_trip_t wr_one_i,
  // held flags
  output uefis_trip_t      flag_o
);

  uefis_trip_t flag_q;
  uefis_trip_t flag_d;

  // ************************************************************
  // flag update
  // ************************************************************
  // a one toggles: clears a set flag, sets a clear one for diagnostics;
  // a live condition wins over the clear in the same cycle
  always_comb begin
    flag_d = uefis_trip_t'(set_i | (flag_q ^ wr_one_i));
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      flag_q <= uefis_trip_t'(UEFIS_RST_FLAGS[UEFIS_TRIP_W-1:0]);
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule

`default_nettype wire

// File: core/uefis_top.sv
/*
 * usb endpoint fifo event status: six flag triplets for fifos 1 to 6,
 * two status words, two enable words and one interrupt request.
 * assumes handshake pulses and endpoint type levels come from the
 * protocol engine on the same 10 mhz clock, and a plain register port
 * whose read data stand in the cycle after the read strobe.
 */
`default_nettype none


module uefis_top
  import uefis_pkg::*;
#(
  parameter int unsigned NUM_FIFO = UEFIS_NUM_FIFO
) (
  // clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       resetn_i,
  // register port
  input  wire logic [31:0]                addr_i,
  input  wire logic [31:0]                wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic [31:0]                     rdata_o,
  // protocol engine, one entry per fifo
  input  wire uefis_evt_t [NUM_FIFO-1:0]  fifo_evt_i,
  input  wire logic [NUM_FIFO-1:0]        fifo_dir_in_i,
  input  wire logic [NUM_FIFO-1:0]        fifo_iso_i,
  // interrupt request
  output logic                            irq_o
);

  // ************************************************************
  // elaboration check
  // ************************************************************
  // the flag layout is fixed by the register words, not scalable
  if (NUM_FIFO != UEFIS_NUM_FIFO) begin : g_bad_num_fifo
    $error("uefis_top: NUM_FIFO must equal the fixed fifo count");
  end

  // the masks gate reads and enable writes, so they must agree with
  // the triplet table or a live flag would read as zero
  function automatic logic [31:0] layout_mask(input bit mid);
    logic [31:0] m;
    m = '0;
    for (int unsigned k = 0; k < UEFIS_NUM_FIFO; k++) begin
      if (UEFIS_TRIP_MID[k] == mid) begin
        m[UEFIS_TRIP_MSB[k] -: UEFIS_TRIP_W] = '1;
      end
    end
    return m;
  endfunction

  if (layout_mask(1'b0) != UEFIS_MASK_LOW || layout_mask(1'b1) != UEFIS_MASK_MID) begin : g_bad_mask
    $error("uefis_top: flag masks disagree with the triplet table");
  end

  // the low word's upper half must always read zero
  if ((UEFIS_MASK_LOW >> ($bits(rdata_o) / 2)) != '0) begin : g_bad_low_half
    $error("uefis_top: low status word reaches into its upper half");
  end

  // ************************************************************
  // declarations
  // ************************************************************
  logic        wr_flags_low;
  logic        wr_flags_mid;
  logic        wr_en_low;
  logic        wr_en_mid;

  logic [31:0] en_low_q;
  logic [31:0] en_mid_q;
  logic [31:0] flags_low;
  logic [31:0] flags_mid;

  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        irq_q;
  logic        irq_d;

  uefis_trip_t flag_w  [NUM_FIFO];
  uefis_trip_t en_w    [NUM_FIFO];
  logic        hit_w   [NUM_FIFO];

  // one name per flag, in register order
  logic        ep0_out_acked;
  logic        ep0_out_refused;
  logic        ep0_out_fault;
  logic        ep0_in_acked;
  logic        ep0_in_refused;
  logic        ep0_in_fault;
  logic        ep1_acked;
  logic        ep1_refused;
  logic        ep1_fault;
  logic        ep2_acked;
  logic        ep2_refused;
  logic        ep2_fault;
  logic        ep3_acked;
  logic        ep3_refused;
  logic        ep3_fault;
  logic        ep4_acked;
  logic        ep4_refused;
  logic        ep4_fault;

  // top bit of each endpoint's triplet within its status word
  localparam int unsigned MSB_EP0_OUT = UEFIS_TRIP_MSB[UEFIS_FIFO_CTRL_OUT];
  localparam int unsigned MSB_EP0_IN  = UEFIS_TRIP_MSB[UEFIS_FIFO_CTRL_IN];
  localparam int unsigned MSB_EP1     = UEFIS_TRIP_MSB[UEFIS_FIFO_CTRL_IN + 1];
  localparam int unsigned MSB_EP2     = UEFIS_TRIP_MSB[UEFIS_FIFO_CTRL_IN + 2];
  localparam int unsigned MSB_EP3     = UEFIS_TRIP_MSB[UEFIS_FIFO_CTRL_IN + 3];
  localparam int unsigned MSB_EP4     = UEFIS_TRIP_MSB[UEFIS_FIFO_CTRL_IN + 4];

  // ************************************************************
  // write decode
  // ************************************************************
  // reads have no side effect, so only writes are decoded here;
  // a write to any other address is dropped without trace
  always_comb begin
    wr_flags_low = wr_i && (addr_i == UEFIS_ADDR_FLAGS_LOW);
    wr_flags_mid = wr_i && (addr_i == UEFIS_ADDR_FLAGS_MID);
    wr_en_low    = wr_i && (addr_i == UEFIS_ADDR_EN_LOW);
    wr_en_mid    = wr_i && (addr_i == UEFIS_ADDR_EN_MID);
  end

  // ************************************************************
  // enable registers
  // ************************************************************
  // only defined flag positions store; the rest stay zero
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      en_low_q <= UEFIS_RST_EN;
    end else if (wr_en_low) begin
      en_low_q <= wdata_i & UEFIS_MASK_LOW;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      en_mid_q <= UEFIS_RST_EN;
    end else if (wr_en_mid) begin
      en_mid_q <= wdata_i & UEFIS_MASK_MID;
    end
  end

  // ************************************************************
  // per fifo condition logic and flag triplets
  // ************************************************************
  for (genvar i = 0; i < NUM_FIFO; i++) begin : g_fifo
    localparam int unsigned MSB = UEFIS_TRIP_MSB[i];
    localparam bit          MID = UEFIS_TRIP_MID[i];

    logic        dir_in;
    logic        iso;
    uefis_evt_t  evt;
    uefis_trip_t set_c;
    uefis_trip_t wr_one_c;
    logic [31:0] src_wdata;
    logic        src_wr;

    // a triplet must fit wholly inside its status word
    if (MSB < UEFIS_TRIP_W - 1 || MSB >= $bits(rdata_o)) begin : g_bad_msb
      $error("uefis_top: flag triplet does not fit its status word");
    end

    // fifo 1 is always control out, fifo 2 always control in;
    // control pipes are never isochronous
    always_comb begin
      if (i == UEFIS_FIFO_CTRL_OUT) begin
        dir_in = 1'b0;
        iso    = 1'b0;
      end else if (i == UEFIS_FIFO_CTRL_IN) begin
        dir_in = 1'b1;
        iso    = 1'b0;
      end else begin
        dir_in = fifo_dir_in_i[i];
        iso    = fifo_iso_i[i];
      end
    end

    // only the dma handshake outcomes feed the flags; fifo level and
    // overrun or underrun of direct mode have no input here
    always_comb begin
      evt = fifo_evt_i[i];
      set_c = '0;
      if (dir_in) begin
        if (iso) begin
          set_c.acked = evt.pkt_sent;
        end else begin
          set_c.acked = evt.host_ack;
          set_c.fault = evt.ack_timeout;
        end
      end else begin
        if (iso) begin
          set_c.acked = evt.pkt_rcvd && !evt.rx_err;
        end else begin
          set_c.acked = evt.ack_sent;
        end
        set_c.fault = evt.rx_err;
      end
      set_c.refused = evt.nak_sent;
    end

    // pick the status word that holds this triplet
    always_comb begin
      src_wr    = MID ? wr_flags_mid : wr_flags_low;
      src_wdata = wdata_i;
      if (src_wr) begin
        wr_one_c = uefis_trip_t'(src_wdata[MSB -: UEFIS_TRIP_W]);
      end else begin
        wr_one_c = '0;
      end
    end

    uefis_flag_cell u_cell (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .set_i    (set_c),
      .wr_one_i (wr_one_c),
      .flag_o   (flag_w[i])
    );

    // enable triplet sits at the same place as its flags
    always_comb begin
      if (MID) begin
        en_w[i] = uefis_trip_t'(en_mid_q[MSB -: UEFIS_TRIP_W]);
      end else begin
        en_w[i] = uefis_trip_t'(en_low_q[MSB -: UEFIS_TRIP_W]);
      end
      hit_w[i] = |(flag_w[i] & en_w[i]);
    end
  end

  // ************************************************************
  // endpoint flag view
  // ************************************************************
  // fifo k from 3 up carries endpoint k-2, so endpoint e sits e
  // entries above the control-in fifo
  always_comb begin
    ep0_out_acked   = flag_w[UEFIS_FIFO_CTRL_OUT].acked;
    ep0_out_refused = flag_w[UEFIS_FIFO_CTRL_OUT].refused;
    ep0_out_fault   = flag_w[UEFIS_FIFO_CTRL_OUT].fault;
    ep0_in_acked    = flag_w[UEFIS_FIFO_CTRL_IN].acked;
    ep0_in_refused  = flag_w[UEFIS_FIFO_CTRL_IN].refused;
    ep0_in_fault    = flag_w[UEFIS_FIFO_CTRL_IN].fault;
    ep1_acked       = flag_w[UEFIS_FIFO_CTRL_IN + 1].acked;
    ep1_refused     = flag_w[UEFIS_FIFO_CTRL_IN + 1].refused;
    ep1_fault       = flag_w[UEFIS_FIFO_CTRL_IN + 1].fault;
    ep2_acked       = flag_w[UEFIS_FIFO_CTRL_IN + 2].acked;
    ep2_refused     = flag_w[UEFIS_FIFO_CTRL_IN + 2].refused;
    ep2_fault       = flag_w[UEFIS_FIFO_CTRL_IN + 2].fault;
    ep3_acked       = flag_w[UEFIS_FIFO_CTRL_IN + 3].acked;
    ep3_refused     = flag_w[UEFIS_FIFO_CTRL_IN + 3].refused;
    ep3_fault       = flag_w[UEFIS_FIFO_CTRL_IN + 3].fault;
    ep4_acked       = flag_w[UEFIS_FIFO_CTRL_IN + 4].acked;
    ep4_refused     = flag_w[UEFIS_FIFO_CTRL_IN + 4].refused;
    ep4_fault       = flag_w[UEFIS_FIFO_CTRL_IN + 4].fault;
  end

  // ************************************************************
  // status word assembly
  // ************************************************************
  // gaps and the low word's upper half are never written, so read zero
  always_comb begin
    flags_low = UEFIS_RST_FLAGS;
    flags_mid = UEFIS_RST_FLAGS;
    flags_low[MSB_EP0_OUT -: UEFIS_TRIP_W] = {ep0_out_acked, ep0_out_refused, ep0_out_fault};
    flags_low[MSB_EP0_IN -: UEFIS_TRIP_W]  = {ep0_in_acked, ep0_in_refused, ep0_in_fault};
    flags_mid[MSB_EP1 -: UEFIS_TRIP_W]     = {ep1_acked, ep1_refused, ep1_fault};
    flags_mid[MSB_EP2 -: UEFIS_TRIP_W]     = {ep2_acked, ep2_refused, ep2_fault};
    flags_mid[MSB_EP3 -: UEFIS_TRIP_W]     = {ep3_acked, ep3_refused, ep3_fault};
    flags_mid[MSB_EP4 -: UEFIS_TRIP_W]     = {ep4_acked, ep4_refused, ep4_fault};
  end

  // ************************************************************
  // read path
  // ************************************************************
  // data stand only in the cycle after the strobe, zero otherwise,
  // which keeps a stale word from being mistaken for a fresh read
  always_comb begin
    rdata_d = UEFIS_RDATA_IDLE;
    if (rd_i) begin
      case (addr_i)
        UEFIS_ADDR_FLAGS_LOW: rdata_d = flags_low & UEFIS_MASK_LOW;
        UEFIS_ADDR_FLAGS_MID: rdata_d = flags_mid & UEFIS_MASK_MID;
        UEFIS_ADDR_EN_LOW:    rdata_d = en_low_q;
        UEFIS_ADDR_EN_MID:    rdata_d = en_mid_q;
        default:              rdata_d = UEFIS_RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rdata_q <= UEFIS_RDATA_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // ************************************************************
  // interrupt request
  // ************************************************************
  // registered for a clean output; it trails the flag by one cycle
  always_comb begin
    irq_d = 1'b0;
    for (int unsigned k = 0; k < NUM_FIFO; k++) begin
      irq_d = irq_d | hit_w[k];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq_o = irq_q;

endmodule

`default_nettype wire

// File: testbench/uefis_top_properties.sv
/*
 * checker of the fifo event status block, bound to uefis_top.
 * assumes register port and event inputs share clock_i.
 */
`default_nettype none

module uefis_top_checker
  import uefis_pkg::*;
#(
  parameter int unsigned NUM_FIFO = UEFIS_NUM_FIFO
) (
  // clock and reset
  input wire logic                      clock_i,
  input wire logic                      resetn_i,
  // register port
  input wire logic [31:0]               addr_i,
  input wire logic [31:0]               wdata_i,
  input wire logic                      wr_i,
  input wire logic                      rd_i,
  input wire logic [31:0]               rdata_o,
  // engine and interrupt
  input wire uefis_evt_t [NUM_FIFO-1:0] fifo_evt_i,
  input wire logic [NUM_FIFO-1:0]       fifo_dir_in_i,
  input wire logic [NUM_FIFO-1:0]       fifo_iso_i,
  input wire logic                      irq_o
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  wire logic rd_lo = rd_i && addr_i == UEFIS_ADDR_FLAGS_LOW;
  wire logic rd_mi = rd_i && addr_i == UEFIS_ADDR_FLAGS_MID;
  wire logic wr_lo = wr_i && addr_i == UEFIS_ADDR_FLAGS_LOW;
  wire logic nak_2 = fifo_evt_i[1].nak_sent;

  property p_rsv_low; rd_lo |=> (rdata_o & ~UEFIS_MASK_LOW) == 32'h0; endproperty
  a_rsv_low: assert property (p_rsv_low) else $error("reserved low bits set");
  property p_rsv_mid; rd_mi |=> (rdata_o & ~UEFIS_MASK_MID) == 32'h0; endproperty
  a_rsv_mid: assert property (p_rsv_mid) else $error("reserved mid bits set");
  property p_refused; nak_2 ##1 rd_lo |=> rdata_o[14]; endproperty
  a_refused: assert property (p_refused) else $error("refused flag missing");
  property p_hold; rd_lo ##1 (rd_lo && rdata_o[14]) |=> rdata_o[14]; endproperty
  a_hold: assert property (p_hold) else $error("flag lost without write");
  // a quiet cycle around the write makes the flag value before it known
  property p_toggle;
    (rd_lo && !nak_2) ##1 (wr_lo && wdata_i[14] && !nak_2) ##1 (rd_lo && !nak_2)
      |=> rdata_o[14] == !$past(rdata_o[14], 2);
  endproperty
  a_toggle: assert property (p_toggle) else $error("write one did not flip flag");
  property p_set_wins; (wr_lo && wdata_i[14] && nak_2) ##1 rd_lo |=> rdata_o[14]; endproperty
  a_set_wins: assert property (p_set_wins) else $error("live condition lost");
  property p_in_ack;
    (fifo_evt_i[3].host_ack && fifo_dir_in_i[3] && !fifo_iso_i[3]) ##1 rd_mi |=> rdata_o[15];
  endproperty
  a_in_ack: assert property (p_in_ack) else $error("in ack flag missing");
  property p_iso_in;
    (fifo_evt_i[2].pkt_sent && fifo_dir_in_i[2] && fifo_iso_i[2]) ##1 rd_mi |=> rdata_o[7];
  endproperty
  a_iso_in: assert property (p_iso_in) else $error("iso in ack missing");
  property p_out_fault; fifo_evt_i[0].rx_err ##1 rd_lo |=> rdata_o[5]; endproperty
  a_out_fault: assert property (p_out_fault) else $error("out fault missing");

  c_set_wins: cover property (wr_lo && wdata_i[14] && nak_2);
  c_irq: cover property (irq_o);
  c_ep4: cover property (rd_mi ##1 rdata_o[31]);
endmodule

bind uefis_top uefis_top_checker #(.NUM_FIFO(NUM_FIFO)) u_chk (
  .clock_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .fifo_evt_i, .fifo_dir_in_i, .fifo_iso_i, .irq_o
);

`default_nettype wire

// File: testbench/uefis_engine_model.sv
/*
 * protocol engine stand-in: one handshake outcome to one fifo.
 * assumes the bench changes its inputs just after clock edges.
 */
`default_nettype none

module uefis_engine_model
  import uefis_pkg::*;
(
  // command from the bench
  input  wire logic       fire_i,
  input  wire logic [2:0] idx_i,
  input  wire uefis_evt_t kind_i,
  // outcomes toward the block
  output uefis_evt_t [5:0] evt_o
);
  // ****************
  // fan-out
  // ****************
  // other fifos stay quiet so a stray flag shows up as a mismatch
  always_comb begin
    evt_o = '0;
    if (fire_i) begin
      evt_o[idx_i] = kind_i;
    end
  end
endmodule

`default_nettype wire

// File: testbench/tb_usb_ep_fifo_irq_status.sv
/*
 * self-checking bench of the fifo event status block.
 * assumes the engine model and the bound checker are compiled with it.
 */
`default_nettype none

module tb_usb_ep_fifo_irq_status
  import uefis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************
  // signals and tables
  // ****************
  localparam logic [1:0]  IDL = 2'b00;
  localparam logic [1:0]  WR  = 2'b10;
  localparam logic [1:0]  RD  = 2'b01;
  localparam logic [31:0] FL  = UEFIS_ADDR_FLAGS_LOW;
  localparam logic [31:0] FM  = UEFIS_ADDR_FLAGS_MID;
  localparam logic [31:0] EL  = UEFIS_ADDR_EN_LOW;
  localparam logic [31:0] EM  = UEFIS_ADDR_EN_MID;
  localparam int          NT  = 15;
  logic             clock_i = 1'b0;
  logic             resetn_i = 1'b0;
  logic             wr_i = 1'b0;
  logic             rd_i = 1'b0;
  logic             fire = 1'b0;
  logic             hold = 1'b0;
  logic             chk = 1'b0;
  logic             chk_irq = 1'b0;
  logic             irq_o;
  logic [2:0]       idx = 3'h0;
  logic [6:0]       ev_k = 7'h0;
  logic [31:0]      addr_i = '0;
  logic [31:0]      wdata_i = '0;
  logic [31:0]      rdata_o;
  logic [31:0]      ex = '0;
  logic [31:0]      ex_irq = '0;
  uefis_evt_t       kind = '0;
  uefis_evt_t [5:0] fifo_evt_i;
  // fifos 1 and 2 get the wrong type on purpose: their type is fixed
  logic [5:0]       fifo_dir_in_i = 6'h0d;
  logic [5:0]       fifo_iso_i = 6'h27;
  int               ev_i = 0;
  int               n_fail = 0;
  int               n_compared = 0;
  int               t_i [NT] = '{1, 1, 0, 0, 0, 1, 2, 2, 3, 3, 4, 4, 5, 5, 5};
  logic [6:0]       t_k [NT] = '{7'h20, 7'h10, 7'h08, 7'h02, 7'h01, 7'h01, 7'h40, 7'h10, 7'h20, 7'h40,
                                 7'h08, 7'h04, 7'h06, 7'h04, 7'h01};
  logic [31:0]      t_x [NT] = '{32'h8000, 32'h2000, 32'h80, 32'h20, 32'h40, 32'h4000, 32'h80, 32'h0,
                                 32'h8000, 32'h0, 32'h80_0000, 32'h0, 32'h2000_0000, 32'h8000_0000,
                                 32'h4000_0000};

  uefis_engine_model u_eng (.fire_i(fire), .idx_i(idx), .kind_i(kind), .evt_o(fifo_evt_i));
  uefis_top u_dut (.clock_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .fifo_evt_i, .fifo_dir_in_i, .fifo_iso_i, .irq_o);

  // ****************
  // tasks
  // ****************
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one bus cycle; a read is checked at the falling edge after its strobe edge
  task automatic acc(input logic [1:0] op, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
    wr_i    <= op[1];
    rd_i    <= op[0];
    addr_i  <= a;
    wdata_i <= d;
    fire    <= hold || ev_k != 7'h0;
    idx     <= 3'(ev_i);
    kind    <= uefis_evt_t'(ev_k);
    @(posedge clock_i);
    chk = op[0];
    ex  = e;
    if (!hold) begin
      ev_k = 7'h0;
    end
  endtask

  // irq is looked at on the falling edge after the last bus cycle;
  // no time passes here, so the next call still drives at a rising edge
  task automatic ck_irq(input logic [31:0] e);
    chk_irq = 1'b1;
    ex_irq  = e;
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************
  // processes
  // ****************
  initial begin
    forever #50 clock_i = ~clock_i;
  end

  always @(negedge clock_i) begin
    if (chk) begin
      ck(rdata_o, ex);
      chk = 1'b0;
    end
    if (chk_irq) begin
      ck(32'(irq_o), ex_irq);
      chk_irq = 1'b0;
    end
  end

  // the tests need some 140 cycles; fourteen times that means a hang
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  initial begin
    logic [31:0] a;
    repeat (12) @(posedge clock_i);
    resetn_i <= 1'b1;
    acc(IDL, '0, '0, '0);
    acc(RD, FL, '0, UEFIS_RST_FLAGS);
    acc(RD, EL, '0, UEFIS_RST_EN);
    acc(RD, EM, '0, UEFIS_RST_EN);
    acc(WR, 32'h9010_3008, '1, '0);
    acc(RD, 32'h9010_3008, '0, UEFIS_RDATA_IDLE);
    acc(WR, FL, ~UEFIS_MASK_LOW, '0);
    acc(WR, FM, ~UEFIS_MASK_MID, '0);
    acc(RD, FL, '0, '0);
    acc(RD, FM, '0, '0);
    acc(WR, FL, UEFIS_MASK_LOW, '0);
    acc(RD, FL, '0, UEFIS_MASK_LOW);
    acc(WR, FL, UEFIS_MASK_LOW, '0);
    acc(RD, FL, '0, '0);
    for (int n = 0; n < NT; n++) begin
      a    = t_i[n] < 2 ? FL : FM;
      ev_i = t_i[n];
      ev_k = t_k[n];
      acc(IDL, '0, '0, '0);
      acc(RD, a, '0, t_x[n]);
      acc(WR, a, '0, '0);
      acc(RD, a, '0, t_x[n]);
      acc(WR, a, t_x[n], '0);
      acc(RD, a, '0, '0);
    end
    acc(WR, FM, UEFIS_MASK_MID, '0);
    acc(WR, EL, '1, '0);
    acc(RD, EL, '0, UEFIS_MASK_LOW);
    acc(WR, EM, '1, '0);
    acc(RD, EM, '0, UEFIS_MASK_MID);
    ck_irq(32'h1);
    acc(WR, EM, '0, '0);
    acc(IDL, '0, '0, '0);
    ck_irq(32'h0);
    acc(WR, EM, 32'h8000_0000, '0);
    acc(IDL, '0, '0, '0);
    ck_irq(32'h1);
    acc(WR, FM, UEFIS_MASK_MID, '0);
    acc(IDL, '0, '0, '0);
    ck_irq(32'h0);
    hold = 1'b1;
    ev_i = 1;
    ev_k = 7'h01;
    acc(IDL, '0, '0, '0);
    acc(WR, FL, 32'h4000, '0);
    acc(RD, FL, '0, 32'h4000);
    acc(RD, FL, '0, 32'h4000);
    ck_irq(32'h1);
    hold = 1'b0;
    ev_k = 7'h0;
    acc(WR, FL, 32'h4000, '0);
    acc(RD, FL, '0, '0);
    ck_irq(32'h0);
    acc(WR, FL, UEFIS_MASK_LOW, '0);
    resetn_i <= 1'b0;
    acc(IDL, '0, '0, '0);
    acc(IDL, '0, '0, '0);
    resetn_i <= 1'b1;
    acc(IDL, '0, '0, '0);
    acc(RD, FL, '0, '0);
    acc(RD, EL, '0, '0);
    ck_irq(32'h0);
    acc(IDL, '0, '0, '0);
    end_of_test();
  end
endmodule

`default_nettype wire
